/* File: sr_host.sv */
// host model that issues decoded status register commands
`timescale 1ns/1ps
module sr_host (
  input wire logic clk_i,
  input wire logic ok_i,
  input wire logic accept_i,
  input wire logic reject_i,
  output sr_protect_pkg::cmd_t cmd_o,
  output logic latch_o
);
  // ------------------------------
  // command issue
  // ------------------------------
  // idle bus and cleared latch at start
  initial begin
    cmd_o = '0;
    latch_o = 1'b0;
  end

  task automatic set_latch(input logic v);
    @(negedge clk_i);
    latch_o = v;
  endtask

  task automatic issue(input logic [7:0] op, input logic [1:0] idx,
                       input logic two, input logic [7:0] d0,
                       input logic [7:0] d1, output logic [2:0] ans);
    @(negedge clk_i);
    cmd_o = '{1'b1, op, idx, two, d0, d1};
    #1;
    ans[2] = ok_i;
    @(negedge clk_i);
    ans[1:0] = {accept_i, reject_i};
    // released bytes must not keep their last value
    cmd_o.valid = 1'b0;
    cmd_o.data0 = ~d0;
    cmd_o.data1 = ~d1;
  endtask
endmodule

/* File: sr_protect.sv */
// status register write protection and pin-function control
`timescale 1ns/1ps
module sr_protect (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  input wire sr_protect_pkg::cmd_t cmd_i,
  input wire logic write_latch_flag_i,
  input wire logic sw_reset_i,
  input wire logic [1:0] nv_protect_mode_i,
  input wire logic permanent_lock_flag_i,
  input wire logic wp_pin_i,
  input wire logic hold_pin_i,
  output logic [7:0] status_two_o,
  output logic protect_mode_low_o,
  output logic hold_select_o,
  output logic wp_is_data_line_two_o,
  output logic hold_is_data_line_three_o,
  output logic hold_active_o,
  output logic quad_cmd_ok_o,
  output logic wr_accept_o,
  output logic wr_reject_o,
  output logic [1:0] prot_type_o
);

  // --------------------------------------------------------------
  // functions
  // --------------------------------------------------------------

  // opcode is one of the quad-gated commands
  function automatic logic is_quad_cmd(input logic [7:0] op);
    is_quad_cmd = (op == sr_protect_pkg::OP_QUAD_RD) ||
                  (op == sr_protect_pkg::OP_DX_RD) ||
                  (op == sr_protect_pkg::OP_DX_RD_DW) ||
                  (op == sr_protect_pkg::OP_QUAD_PP) ||
                  (op == sr_protect_pkg::OP_BURST_WRAP) ||
                  (op == sr_protect_pkg::OP_QUAD_ID);
  endfunction

  // protection type from mode bits and lock
  function automatic sr_protect_pkg::prot_t prot_of(
    input logic [1:0] pm, input logic lock);
    if (pm == sr_protect_pkg::PM_SOFT) begin
      prot_of = sr_protect_pkg::PROT_SOFT;
    end else if (pm == sr_protect_pkg::PM_HARD) begin
      prot_of = sr_protect_pkg::PROT_HARD;
    end else if (pm == sr_protect_pkg::PM_LOCK_OTP && lock) begin
      prot_of = sr_protect_pkg::PROT_OTP;
    end else begin
      prot_of = sr_protect_pkg::PROT_LOCKDOWN;
    end
  endfunction

  // --------------------------------------------------------------
  // pin synchronisers
  // --------------------------------------------------------------

  logic [1:0] wp_sync_q;
  logic [1:0] hold_sync_q;

  // two stages before any logic reads the pins
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      wp_sync_q <= 2'h3;
      hold_sync_q <= 2'h3;
    end else if (ce_i) begin
      wp_sync_q <= {wp_sync_q[0], wp_pin_i};
      hold_sync_q <= {hold_sync_q[0], hold_pin_i};
    end
  end

  // --------------------------------------------------------------
  // state
  // --------------------------------------------------------------

  logic qe_q;
  logic pmh_q;
  logic pml_q;
  logic hold_sel_q;
  logic reload_q;
  logic wr_accept_q;
  logic wr_reject_q;
  logic [1:0] pm;
  logic wp_eff;
  logic hw_reset;
  logic is_wr;
  logic allowed;
  logic accept;
  logic hit_sr1;
  logic hit_sr2;
  logic hit_sr3;
  logic [7:0] sr2_byte;
  sr_protect_pkg::prot_t prot;

  assign pm = {pmh_q, pml_q};
  assign prot = prot_of(pm, permanent_lock_flag_i);

  // pin function off
  // write-protect pin reads high once it is a data line
  assign wp_eff = qe_q ? 1'b1 : wp_sync_q[1];

  // select needs quad off
  // pin reset only while the pin keeps its own function
  assign hw_reset = !qe_q && hold_sel_q && !hold_sync_q[1];

  // decode the write commands
  assign is_wr = cmd_i.valid &&
    ((cmd_i.opcode == sr_protect_pkg::OP_WR_SR1) ||
     (cmd_i.opcode == sr_protect_pkg::OP_WR_SR2) ||
     (cmd_i.opcode == sr_protect_pkg::OP_WR_SR3) ||
     (cmd_i.opcode == sr_protect_pkg::OP_WR_ANY));

  always_comb begin
    case (prot)
      sr_protect_pkg::PROT_SOFT: allowed = 1'b1;
      sr_protect_pkg::PROT_HARD: allowed = wp_eff;
      default: allowed = 1'b0;
    endcase
  end

  // no write while the protect bits are being reloaded
  assign accept = is_wr && allowed && write_latch_flag_i &&
                  !reload_q && !hw_reset;

  // which registers a write targets
  assign hit_sr1 = (cmd_i.opcode == sr_protect_pkg::OP_WR_SR1) ||
    (cmd_i.opcode == sr_protect_pkg::OP_WR_ANY &&
     cmd_i.index == sr_protect_pkg::IDX_SR1);
  assign hit_sr2 = (cmd_i.opcode == sr_protect_pkg::OP_WR_SR2) ||
    (cmd_i.opcode == sr_protect_pkg::OP_WR_SR1 && cmd_i.two_bytes) ||
    (cmd_i.opcode == sr_protect_pkg::OP_WR_ANY &&
     cmd_i.index == sr_protect_pkg::IDX_SR2);
  assign hit_sr3 = (cmd_i.opcode == sr_protect_pkg::OP_WR_SR3) ||
    (cmd_i.opcode == sr_protect_pkg::OP_WR_ANY &&
     cmd_i.index == sr_protect_pkg::IDX_SR3);

  // second byte of 01h carries register two
  assign sr2_byte = (cmd_i.opcode == sr_protect_pkg::OP_WR_SR1) ?
                    cmd_i.data1 : cmd_i.data0;

  // reload pending after any reset source
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      reload_q <= 1'b1;
    end else if (ce_i) begin
      reload_q <= sw_reset_i || hw_reset;
    end
  end

  // --------------------------------------------------------------
  // protect-mode bits
  // --------------------------------------------------------------

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      pmh_q <= sr_protect_pkg::RST_PMH;
      pml_q <= sr_protect_pkg::RST_PML;
    end else if (ce_i) begin
      if (reload_q) begin
        case (nv_protect_mode_i)
          sr_protect_pkg::PM_SOFT: {pmh_q, pml_q} <= 2'h0;
          sr_protect_pkg::PM_HARD: {pmh_q, pml_q} <= 2'h1;
          sr_protect_pkg::PM_LOCKDOWN: {pmh_q, pml_q} <= 2'h0;
          default: begin
            {pmh_q, pml_q} <= permanent_lock_flag_i ? 2'h3 : 2'h1;
          end
        endcase
      end else if (accept) begin
        if (hit_sr1) begin
          pml_q <= cmd_i.data0[sr_protect_pkg::PML_BIT];
        end
        if (hit_sr2) begin
          pmh_q <= sr2_byte[sr_protect_pkg::PMH_BIT];
        end
      end
    end
  end

  // --------------------------------------------------------------
  // quad enable and hold select
  // --------------------------------------------------------------

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      qe_q <= sr_protect_pkg::RST_QE;
    end else if (ce_i && accept && hit_sr2) begin
      qe_q <= sr2_byte[sr_protect_pkg::QE_BIT];
    end
  end

  // hold versus reset select of register three
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      hold_sel_q <= sr_protect_pkg::RST_HOLD_SEL;
    end else if (ce_i && accept && hit_sr3) begin
      hold_sel_q <= cmd_i.data0[sr_protect_pkg::HOLD_SEL_BIT];
    end
  end

  // one-cycle outcome of each write command
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      wr_accept_q <= 1'b0;
      wr_reject_q <= 1'b0;
    end else if (ce_i) begin
      wr_accept_q <= accept;
      wr_reject_q <= is_wr && !accept;
    end
  end

  // --------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------

  // register two view, unheld bits read zero
  always_comb begin
    status_two_o = 8'h00;
    status_two_o[sr_protect_pkg::QE_BIT] = qe_q;
    status_two_o[sr_protect_pkg::PMH_BIT] = pmh_q;
  end

  assign protect_mode_low_o = pml_q;
  assign hold_select_o = hold_sel_q;
  assign prot_type_o = prot;
  assign wr_accept_o = wr_accept_q;
  assign wr_reject_o = wr_reject_q;

  assign wp_is_data_line_two_o = qe_q;
  assign hold_is_data_line_three_o = qe_q;
  assign hold_active_o = !qe_q && !hold_sel_q && !hold_sync_q[1];

  assign quad_cmd_ok_o = !(cmd_i.valid && is_quad_cmd(cmd_i.opcode))
                         || qe_q;

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------

  property p_hard_low_reject;
    @(posedge clk_i) disable iff (!nrst_i)
    (ce_i && is_wr && pm == 2'h1 && !qe_q && !wp_sync_q[1])
      |=> (wr_reject_o && !wr_accept_o);
  endproperty
  a_hard_low_reject: assert property (p_hard_low_reject)
    else $error("write taken with hardware protection active");
  property p_soft_accept;
    @(posedge clk_i) disable iff (!nrst_i)
    (ce_i && is_wr && pm == 2'h0 && write_latch_flag_i &&
     !reload_q && !hw_reset) |=> wr_accept_o;
  endproperty
  a_soft_accept: assert property (p_soft_accept)
    else $error("software protected write not taken");
  property p_hard_high_accept;
    @(posedge clk_i) disable iff (!nrst_i)
    (ce_i && is_wr && pm == 2'h1 && wp_eff && write_latch_flag_i &&
     !reload_q && !hw_reset) |=> wr_accept_o;
  endproperty
  a_hard_high_accept: assert property (p_hard_high_accept)
    else $error("unprotected hardware write not taken");
  property p_lockdown;
    @(posedge clk_i) disable iff (!nrst_i)
    (ce_i && is_wr && pm == 2'h2) |=> !wr_accept_o;
  endproperty
  a_lockdown: assert property (p_lockdown)
    else $error("write taken in reset lockdown");
  property p_otp_hold;
    @(posedge clk_i) disable iff (!nrst_i)
    (ce_i && pm == 2'h3 && permanent_lock_flag_i && !reload_q)
      |=> (pm == 2'h3);
  endproperty
  a_otp_hold: assert property (p_otp_hold)
    else $error("permanently locked mode bits changed");
  property p_reload_lock_release;
    @(posedge clk_i) disable iff (!nrst_i)
    (ce_i && reload_q && nv_protect_mode_i == 2'h2)
      |=> (status_two_o[0] == 1'b0 && !protect_mode_low_o);
  endproperty
  a_reload_lock_release: assert property (p_reload_lock_release)
    else $error("reload of lockdown copy did not clear mode");
  property p_reload_soft_lock;
    @(posedge clk_i) disable iff (!nrst_i)
    (ce_i && reload_q && nv_protect_mode_i == 2'h3 &&
     !permanent_lock_flag_i) |=> (pm == 2'h1);
  endproperty
  a_reload_soft_lock: assert property (p_reload_soft_lock)
    else $error("reload of unlocked 11 did not give 01");
  property p_reject_no_change;
    @(posedge clk_i) disable iff (!nrst_i)
    (ce_i && is_wr && !accept && !reload_q)
      |=> $stable(status_two_o) && $stable(protect_mode_low_o);
  endproperty
  a_reject_no_change: assert property (p_reject_no_change)
    else $error("rejected write changed a status bit");
  property p_quad_gate;
    @(posedge clk_i) disable iff (!nrst_i)
    (cmd_i.valid && is_quad_cmd(cmd_i.opcode) && !status_two_o[1])
      |-> !quad_cmd_ok_o;
  endproperty
  a_quad_gate: assert property (p_quad_gate)
    else $error("quad command allowed with quad off");
  property p_hold_role;
    @(posedge clk_i) disable iff (!nrst_i)
    status_two_o[1] |-> (!hold_active_o && wp_is_data_line_two_o);
  endproperty
  a_hold_role: assert property (p_hold_role)
    else $error("pin function active while quad is on");

endmodule

/* File: sr_protect_pkg.sv */
// constants and types for status register write protection
package sr_protect_pkg;

  // opcodes of the status register writes
  localparam logic [7:0] OP_WR_SR1 = 8'h01;
  localparam logic [7:0] OP_WR_SR2 = 8'h31;
  localparam logic [7:0] OP_WR_SR3 = 8'h11;
  localparam logic [7:0] OP_WR_ANY = 8'h71;
  // opcodes gated by quad enable
  localparam logic [7:0] OP_QUAD_RD = 8'h6B;
  localparam logic [7:0] OP_DX_RD = 8'hEB;
  localparam logic [7:0] OP_DX_RD_DW = 8'hE7;
  localparam logic [7:0] OP_QUAD_PP = 8'h32;
  localparam logic [7:0] OP_BURST_WRAP = 8'h77;
  localparam logic [7:0] OP_QUAD_ID = 8'h94;

  // register index for the 71h form
  localparam logic [1:0] IDX_SR1 = 2'h1;
  localparam logic [1:0] IDX_SR2 = 2'h2;
  localparam logic [1:0] IDX_SR3 = 2'h3;

  // field positions
  localparam int QE_BIT = 1;
  localparam int PMH_BIT = 0;
  localparam int PML_BIT = 7;
  localparam int HOLD_SEL_BIT = 7;

  // values after reset
  localparam logic RST_QE = 1'h0;
  localparam logic RST_PMH = 1'h0;
  localparam logic RST_PML = 1'h0;
  localparam logic RST_HOLD_SEL = 1'h0;

  // protect-mode encodings, {high, low}
  localparam logic [1:0] PM_SOFT = 2'h0;
  localparam logic [1:0] PM_HARD = 2'h1;
  localparam logic [1:0] PM_LOCKDOWN = 2'h2;
  localparam logic [1:0] PM_LOCK_OTP = 2'h3;

  typedef struct packed {
    logic valid;
    logic [7:0] opcode;
    logic [1:0] index;
    logic two_bytes;
    logic [7:0] data0;
    logic [7:0] data1;
  } cmd_t;

  typedef enum logic [1:0] {
    PROT_SOFT,
    PROT_HARD,
    PROT_LOCKDOWN,
    PROT_OTP
  } prot_t;

endpackage

/* File: testbench.sv */
// self-checking bench for status register write protection
`timescale 1ns/1ps
module testbench;
  logic clk_i, nrst_i, ce_i, sw_reset_i, lock, wp_pin, hold_pin, latch;
  logic pml, hold_sel, dl2, dl3, hold_act, quad_ok, acc, rej;
  logic [1:0] nv, prot, e;
  logic [2:0] ans;
  logic [7:0] status_two, d, sr2;
  logic [7:0] qops [6];
  sr_protect_pkg::cmd_t cmd;
  int miscompares, check_count, cycles, seed;

  sr_protect sr_protect_i (.clk_i(clk_i), .nrst_i(nrst_i), .ce_i(ce_i),
    .cmd_i(cmd), .write_latch_flag_i(latch), .sw_reset_i(sw_reset_i),
    .nv_protect_mode_i(nv), .permanent_lock_flag_i(lock),
    .wp_pin_i(wp_pin), .hold_pin_i(hold_pin), .status_two_o(status_two),
    .protect_mode_low_o(pml), .hold_select_o(hold_sel),
    .wp_is_data_line_two_o(dl2), .hold_is_data_line_three_o(dl3),
    .hold_active_o(hold_act), .quad_cmd_ok_o(quad_ok),
    .wr_accept_o(acc), .wr_reject_o(rej), .prot_type_o(prot));

  sr_host sr_host_i (.clk_i(clk_i), .ok_i(quad_ok), .accept_i(acc),
    .reject_i(rej), .cmd_o(cmd), .latch_o(latch));

  // ------------------------------
  // clock, timeout, helpers
  // ------------------------------
  // free running clock, 10 ns period
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // hang guard
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      test_done();
    end
  end

  // mode bits expected after a reload
  function automatic logic [1:0] exp_reload(input logic [1:0] m,
                                            input logic l);
    case (m)
      2'h2: return 2'h0;
      2'h3: return l ? 2'h3 : 2'h1;
      default: return m;
    endcase
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] op, input logic [1:0] idx,
                    input logic two, input logic [7:0] d0,
                    input logic [7:0] d1, input logic ok);
    sr_host_i.issue(op, idx, two, d0, d1, ans);
    chk({6'h0, ans[1:0]}, ok ? 8'h02 : 8'h01);
  endtask

  task automatic do_reset(input logic [1:0] m, input logic l);
    @(negedge clk_i);
    nv = m;
    lock = l;
    nrst_i = 1'b0;
    repeat (3) @(negedge clk_i);
    nrst_i = 1'b1;
    repeat (2) @(negedge clk_i);
  endtask

  task automatic pulse_sw(input logic [1:0] m);
    @(negedge clk_i);
    nv = m;
    sw_reset_i = 1'b1;
    @(negedge clk_i);
    sw_reset_i = 1'b0;
    repeat (2) @(negedge clk_i);
  endtask

  task automatic pins(input logic w, input logic h);
    @(negedge clk_i);
    wp_pin = w;
    hold_pin = h;
    repeat (3) @(negedge clk_i);
  endtask

  task automatic quad_loop(input logic q);
    foreach (qops[k]) begin
      sr_host_i.issue(qops[k], 2'h0, 1'b0, 8'h00, 8'h00, ans);
      chk({7'h0, ans[2]}, {7'h0, q});
    end
    sr_host_i.issue(8'h03, 2'h0, 1'b0, 8'h00, 8'h00, ans);
    chk({7'h0, ans[2]}, 8'h01);
  endtask

  task automatic test_done();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ------------------------------
  // main sequence
  // ------------------------------
  initial begin
    ce_i = 1'b1;
    nrst_i = 1'b0;
    sw_reset_i = 1'b0;
    nv = 2'h0;
    lock = 1'b0;
    wp_pin = 1'b1;
    hold_pin = 1'b1;
    qops = '{sr_protect_pkg::OP_QUAD_RD, sr_protect_pkg::OP_DX_RD,
      sr_protect_pkg::OP_DX_RD_DW, sr_protect_pkg::OP_QUAD_PP,
      sr_protect_pkg::OP_BURST_WRAP, sr_protect_pkg::OP_QUAD_ID};
    seed = $urandom(42);
    sr_host_i.set_latch(1'b1);
    // reload table over every copy and lock value
    for (int i = 0; i < 8; i++) begin
      do_reset(i[1:0], i[2]);
      e = exp_reload(i[1:0], i[2]);
      chk(status_two, {7'h0, e[1]});
      chk({7'h0, pml}, {7'h0, e[0]});
      chk({6'h0, prot}, {6'h0, e});
      wr(8'h31, 2'h2, 1'b0, 8'h00, 8'h00, e != 2'h3);
    end
    pulse_sw(2'h3);
    wr(8'h31, 2'h2, 1'b0, 8'h00, 8'h00, 1'b0);
    // random writes in software mode, latch and pin random
    do_reset(2'h0, 1'b0);
    sr2 = 8'h00;
    for (int i = 0; i < 8; i++) begin
      sr_host_i.set_latch(1'($urandom));
      wp_pin = 1'($urandom);
      d = 8'($urandom) & 8'hFE;
      wr(i[0] ? 8'h31 : 8'h71, 2'h2, 1'b0, d, ~d, latch);
      if (latch)
        sr2 = d & 8'h02;
      chk(status_two, sr2);
    end
    sr_host_i.set_latch(1'b1);
    // pin functions and quad gate
    pins(1'b1, 1'b1);
    wr(8'h31, 2'h2, 1'b0, 8'h00, 8'h00, 1'b1);
    pins(1'b1, 1'b0);
    chk({5'h0, hold_act, dl2, dl3}, 8'h04);
    pins(1'b1, 1'b1);
    quad_loop(1'b0);
    wr(8'h31, 2'h2, 1'b0, 8'h02, 8'h00, 1'b1);
    pins(1'b1, 1'b0);
    chk({5'h0, hold_act, dl2, dl3}, 8'h03);
    quad_loop(1'b1);
    // reset select is inert while quad is on
    wr(8'h11, 2'h3, 1'b0, 8'h80, 8'h00, 1'b1);
    chk({7'h0, hold_sel}, 8'h01);
    wr(8'h31, 2'h2, 1'b0, 8'h00, 8'h00, 1'b1);
    wr(8'h31, 2'h2, 1'b0, 8'h00, 8'h00, 1'b0);
    pins(1'b1, 1'b1);
    // hardware mode with pin low then high
    wr(8'h01, 2'h0, 1'b0, 8'h80, 8'h00, 1'b1);
    chk({6'h0, prot}, 8'h01);
    pins(1'b0, 1'b1);
    wr(8'h31, 2'h2, 1'b0, 8'h02, 8'h00, 1'b0);
    chk(status_two, 8'h00);
    pins(1'b1, 1'b1);
    wr(8'h31, 2'h2, 1'b0, 8'h00, 8'h00, 1'b1);
    // reset lockdown, lifted by a software reset
    wr(8'h01, 2'h0, 1'b1, 8'h00, 8'h01, 1'b1);
    chk({6'h0, prot}, 8'h02);
    wr(8'h31, 2'h2, 1'b0, 8'h02, 8'h00, 1'b0);
    chk({5'h0, status_two[1:0], pml}, 8'h02);
    pulse_sw(2'h2);
    chk({5'h0, status_two[1:0], pml}, 8'h00);
    // both mode bits set without the lock
    wr(8'h71, 2'h1, 1'b0, 8'h80, 8'h00, 1'b1);
    wr(8'h31, 2'h2, 1'b0, 8'h01, 8'h00, 1'b1);
    chk({6'h0, prot}, 8'h02);
    wr(8'h31, 2'h2, 1'b0, 8'h00, 8'h00, 1'b0);
    pulse_sw(2'h3);
    chk({5'h0, status_two[1:0], pml}, 8'h01);
    // frozen clock enable: a command leaves no trace
    @(negedge clk_i);
    ce_i = 1'b0;
    sr_host_i.issue(8'h31, 2'h2, 1'b0, 8'h02, 8'h00, ans);
    chk({6'h0, ans[1:0]}, 8'h00);
    chk(status_two, 8'h00);
    ce_i = 1'b1;
    wr(8'h31, 2'h2, 1'b0, 8'h02, 8'h00, 1'b1);
    chk(status_two, 8'h02);
    test_done();
  end
endmodule
